// file: inc/pixel_port_consts.svh
// constants for the parallel pixel output port
`ifndef PIXEL_PORT_CONSTS_SVH
`define PIXEL_PORT_CONSTS_SVH

`define PIX_W             10
`define FIFO_DEPTH        32
`define APB_AW            12
`define CNT_W             16

`define ADDR_CTRL         12'h000
`define ADDR_HACT         12'h004
`define ADDR_HBLK         12'h008
`define ADDR_NROWS        12'h00C
`define ADDR_VBLK         12'h010
`define ADDR_EXPO         12'h014
`define ADDR_STATUS       12'h018
`define IDX_PCLK_CTL      12'h072
`define ADDR_PCLK_CTL     (`IDX_PCLK_CTL << 2)

`define CTRL_RUN_BIT      0
`define CTRL_MODE_LO      1
`define CTRL_MODE_HI      2
`define PCLK_INV_BIT      4
`define ST_STATE_HI       6
`define ST_UNDERRUN_BIT   8
`define ST_IMG_SYNC_BIT   9
`define ST_ROW_SYNC_BIT   10
`define ST_STANDBY_BIT    11

`define HACT_RST          16'h02F0
`define HBLK_RST          16'h005E
`define NROWS_RST         16'h01E0
`define VBLK_RST          16'h002D
`define EXPO_RST          16'h0010
`define FRAME_END_BLANK   16'h0017

`define CLK_KHZ           125000
`define SCLK_TARGET_KHZ   26600
`endif

// file: inc/pixel_port_pkg.sv
// types shared by the parallel pixel output port
package pixel_port_pkg;
   typedef enum logic [6:0] {
      S_IDLE   = 7'h01,
      S_EXPOSE = 7'h02,
      S_FSTART = 7'h04,
      S_ACTIVE = 7'h08,
      S_HBLANK = 7'h10,
      S_FEND   = 7'h20,
      S_VBLANK = 7'h40
   } seq_state_e;

   typedef enum logic [1:0] {
      MODE_MASTER   = 2'h0,
      MODE_SNAPSHOT = 2'h1,
      MODE_SLAVE    = 2'h2,
      MODE_RSVD     = 2'h3
   } run_mode_e;

   typedef struct packed {
      logic        frame;
      logic        row;
      logic [9:0]  data;
   } video_s;

   typedef struct packed {
      logic        run;
      run_mode_e   mode;
      logic [15:0] hact;
      logic [15:0] hblk;
      logic [15:0] nrows;
      logic [15:0] vblk;
      logic [15:0] expo;
      logic        inv;
   } cfg_s;
endpackage

// file: hdl/pixel_port.sv
// pixel fifo and parallel pixel output port with apb registers
//
// Notes on behaviour
// (RQ1) output enable low floats pixel bus, row, frame flags, sample clock.
// (RQ2) snapshot and slave modes start exposure on exposure trigger rising edge.
// (RQ3) reset returns every control register to its default value.
// (RQ4) receiver captures pixel bus on rising sample clock edge.
// (RQ5) row and frame flags high only while bus carries valid samples; frame flag here is also high in S_FSTART, S_HBLANK and S_FEND.
// (RQ6) master drives row start sync; slave takes it as input.
// (RQ7) master drives image start sync; slave samples it as input.
// (RQ8) serial control address comes from two address select pins.
// (RQ9) standby input halts sensor operation.
// (RQ10) master input clock lies between 13 and 27 MHz; CLOCK is 125 MHz, divided by 6 to a 20.8 MHz sample clock.
// (RQ11) one pixel per sample clock period while row flag high.
// (RQ12) sample clock keeps toggling, also during blanking.
// (RQ13) bit 4 of the clock control register inverts sample clock.
// (RQ14) frame flag brackets all row pulses of its frame.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "pixel_port_consts.svh"

module pixel_fifo #(
   parameter int W     = `PIX_W,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input  wire logic         clk,       // core clock
   input  wire logic         rst_n,     // synchronous reset, active low
   input  wire logic         ce,        // clock enable
   input  wire logic         in_valid,  // write side valid
   input  wire logic [W-1:0] in_data,   // write side data
   output logic              in_ready,  // not full
   output logic              out_valid, // not empty
   output logic [W-1:0]      out_data,  // head word
   input  wire logic         out_ready  // read side takes head
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [W-1:0]  mem [DEPTH];
   logic [AW-1:0] wptr, rptr, next_wptr, next_rptr;
   logic [AW:0]   count, next_count;
   logic          full, empty, next_full, next_empty, push, pop;

   function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
      return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   always_comb begin
      push       = in_valid & ~full;
      pop        = out_ready & ~empty;
      next_wptr  = push ? wrap_inc(wptr) : wptr;
      next_rptr  = pop ? wrap_inc(rptr) : rptr;
      next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      next_full  = (next_count == (AW + 1)'(DEPTH));
      next_empty = (next_count == '0);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wptr  <= '0;
         rptr  <= '0;
         count <= '0;
         in_ready <= 1'b1;
         empty <= 1'b1;
      end else if (ce) begin
         wptr  <= next_wptr;
         rptr  <= next_rptr;
         count <= next_count;
         in_ready <= ~next_full;
         empty <= next_empty;
         if (push) begin
            mem[wptr] <= in_data;
         end
      end
   end

   // ready is registered so the top level output comes from a flop
   assign full      = ~in_ready;
   assign out_valid = ~empty;
   assign out_data  = mem[rptr];
endmodule

module pixel_port #(
   parameter int        FIFO_DEPTH = `FIFO_DEPTH,
   parameter logic [6:0] ADDR_BASE = 7'h50  // arbitrary neutral value
) (
   input  wire logic         CLOCK,             // 125 MHz core clock
   input  wire logic         RST_N,             // synchronous reset
   input  wire logic         CE,                // clock enable
   input  wire logic         PSEL,              // apb select
   input  wire logic         PENABLE,           // apb enable
   input  wire logic         PWRITE,            // apb direction
   input  wire logic [11:0]  PADDR,             // apb byte address
   input  wire logic [31:0]  PWDATA,            // apb write data
   output logic [31:0]       PRDATA,            // apb read data
   output logic              PREADY,            // apb ready
   output logic              PSLVERR,           // apb error
   input  wire logic         PIX_VALID,         // pixel source valid
   input  wire logic [9:0]   PIX_DATA,          // pixel source data
   output logic              PIX_READY,         // pixel fifo not full
   input  wire logic         OUTPUT_ENABLE_IN,  // video drive enable pin
   input  wire logic         STANDBY_IN,        // standby pin
   input  wire logic         EXPOSURE_IN,       // exposure trigger pin
   input  wire logic         ROW_START_SYNC_IN, // row sync pin level
   input  wire logic         IMAGE_START_SYNC_IN, // image sync pin level
   input  wire logic         CTRL_ADDR_SELECT_LO, // address select pin
   input  wire logic         CTRL_ADDR_SELECT_HI, // address select pin
   output logic [9:0]        DATA_OUT,          // pixel bus
   output logic              ROW_ACTIVE_OUT,    // row-active flag
   output logic              FRAME_ACTIVE_OUT,  // frame-active flag
   output logic              SAMPLE_CLOCK_OUT,  // forwarded sample clock
   output logic              VIDEO_OE,          // drive enable, video pins
   output logic              ROW_START_SYNC_OUT, // row sync drive
   output logic              ROW_START_SYNC_OE,  // row sync enable
   output logic              IMAGE_START_SYNC_OUT, // image sync drive
   output logic              IMAGE_START_SYNC_OE,  // image sync enable
   output logic              STROBE_LIGHT_OUT,  // high during exposure
   output logic [6:0]        SERIAL_ADDR        // serial control address
);
   localparam int HALF = (`CLK_KHZ + 2 * `SCLK_TARGET_KHZ - 1)
                         / (2 * `SCLK_TARGET_KHZ);
   localparam logic [7:0] HALF_M1 = 8'(HALF - 1);

   // ---- pin synchronisers
   logic [6:0] s1, s2, s3, next_s1;
   logic       oe_s, stby_s, exp_rise, row_rise, row_lvl, img_lvl;
   always_comb begin
      next_s1 = {CTRL_ADDR_SELECT_HI, CTRL_ADDR_SELECT_LO,
                 IMAGE_START_SYNC_IN, ROW_START_SYNC_IN, EXPOSURE_IN,
                 STANDBY_IN, OUTPUT_ENABLE_IN};
   end
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else if (CE) begin
         s1 <= next_s1;
         s2 <= s1;
         s3 <= s2;
      end
   end
   assign oe_s     = s2[0];
   assign stby_s   = s2[1];
   assign exp_rise = s2[2] & ~s3[2];
   assign row_rise = s2[3] & ~s3[3];
   assign row_lvl  = s2[3];
   assign img_lvl  = s2[4];

   // ---- apb slave and configuration
   pixel_port_pkg::cfg_s       cfg, next_cfg;
   pixel_port_pkg::seq_state_e st, next_st;
   logic [31:0] next_prdata;
   logic        next_pready, next_pslverr, apb_wr, setup, mapped;
   logic        underrun, next_underrun, status_clr;
   assign setup  = PSEL & ~PENABLE & ~PREADY;
   assign apb_wr = PSEL & PENABLE & PREADY & PWRITE;
   assign status_clr = apb_wr && (PADDR == `ADDR_STATUS)
                       && PWDATA[`ST_UNDERRUN_BIT];

   function automatic logic is_mapped(input logic [11:0] a);
      return (a == `ADDR_CTRL) || (a == `ADDR_HACT) || (a == `ADDR_HBLK)
          || (a == `ADDR_NROWS) || (a == `ADDR_VBLK) || (a == `ADDR_EXPO)
          || (a == `ADDR_STATUS) || (a == `ADDR_PCLK_CTL);
   endfunction

   always_comb begin
      next_cfg     = cfg;
      mapped       = is_mapped(PADDR);
      next_pready  = setup;
      next_pslverr = setup & ~mapped;
      next_prdata  = PRDATA;
      if (setup) begin
         next_prdata = 32'h0000_0000;
         case (PADDR)
            `ADDR_CTRL:  next_prdata[2:0] = {cfg.mode, cfg.run};
            `ADDR_HACT:  next_prdata[15:0] = cfg.hact;
            `ADDR_HBLK:  next_prdata[15:0] = cfg.hblk;
            `ADDR_NROWS: next_prdata[15:0] = cfg.nrows;
            `ADDR_VBLK:  next_prdata[15:0] = cfg.vblk;
            `ADDR_EXPO:  next_prdata[15:0] = cfg.expo;
            `ADDR_STATUS: begin
               next_prdata[`ST_STATE_HI:0]   = st;
               next_prdata[`ST_UNDERRUN_BIT] = underrun;
               next_prdata[`ST_IMG_SYNC_BIT] = img_lvl;  // see RQ7
               next_prdata[`ST_ROW_SYNC_BIT] = row_lvl;  // see RQ6
               next_prdata[`ST_STANDBY_BIT]  = stby_s;
            end
            `ADDR_PCLK_CTL: next_prdata[`PCLK_INV_BIT] = cfg.inv;
            default: next_prdata = 32'h0000_0000;
         endcase
      end
      if (apb_wr) begin
         case (PADDR)
            `ADDR_CTRL: begin
               next_cfg.run  = PWDATA[`CTRL_RUN_BIT];
               next_cfg.mode = pixel_port_pkg::run_mode_e'(
                                  PWDATA[`CTRL_MODE_HI:`CTRL_MODE_LO]);
            end
            `ADDR_HACT:     next_cfg.hact  = PWDATA[15:0];
            `ADDR_HBLK:     next_cfg.hblk  = PWDATA[15:0];
            `ADDR_NROWS:    next_cfg.nrows = PWDATA[15:0];
            `ADDR_VBLK:     next_cfg.vblk  = PWDATA[15:0];
            `ADDR_EXPO:     next_cfg.expo  = PWDATA[15:0];
            `ADDR_PCLK_CTL: next_cfg.inv   = PWDATA[`PCLK_INV_BIT]; // see RQ13
            default: next_cfg = cfg;
         endcase
      end
   end
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         // see RQ3
         cfg.run   <= 1'b0;
         cfg.mode  <= pixel_port_pkg::MODE_MASTER;
         cfg.hact  <= `HACT_RST;
         cfg.hblk  <= `HBLK_RST;
         cfg.nrows <= `NROWS_RST;
         cfg.vblk  <= `VBLK_RST;
         cfg.expo  <= `EXPO_RST;
         cfg.inv   <= 1'b0;
         PRDATA    <= 32'h0000_0000;
         PREADY    <= 1'b0;
         PSLVERR   <= 1'b0;
      end else if (CE) begin
         cfg     <= next_cfg;
         PRDATA  <= next_prdata;
         PREADY  <= next_pready;
         PSLVERR <= next_pslverr;
      end
   end

   // ---- sample clock divider, free running (see RQ12)
   logic [7:0] dcnt, next_dcnt;
   logic       sclk, next_sclk, next_pin, pix_tick;
   always_comb begin
      next_dcnt = (dcnt == HALF_M1) ? 8'h00 : dcnt + 8'h01;
      next_sclk = (dcnt == HALF_M1) ? ~sclk : sclk;
      next_pin  = next_sclk ^ next_cfg.inv;  // see RQ13
      // data moves as the pin falls, so it is steady at the pin rise
      pix_tick  = (dcnt == HALF_M1) && (sclk ^ cfg.inv);  // see RQ4
   end
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         dcnt             <= 8'h00;
         sclk             <= 1'b0;
         SAMPLE_CLOCK_OUT <= 1'b0;
      end else if (CE) begin
         dcnt             <= next_dcnt;
         sclk             <= next_sclk;
         SAMPLE_CLOCK_OUT <= next_pin;
      end
   end

   // ---- frame sequencer
   pixel_port_pkg::video_s vid, next_vid;
   logic [15:0] cnt, row, next_cnt, next_row, p1, rowlen;
   logic        expo_pend, row_pend, next_expo_pend, next_row_pend;
   logic        clr_expo, clr_row, pop, fifo_valid, row_go, slave;
   logic        next_strobe, next_row_o, next_img_o;
   logic [9:0]  fifo_data;

   pixel_fifo #(.W(`PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (CLOCK),
      .rst_n     (RST_N),
      .ce        (CE),
      .in_valid  (PIX_VALID),
      .in_data   (PIX_DATA),
      .in_ready  (PIX_READY),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (pop)
   );

   function automatic logic at_end(input logic [15:0] c,
                                   input logic [15:0] n);
      return (n == 16'h0000) || (c == n - 16'h0001);
   endfunction

   always_comb begin
      slave    = (cfg.mode == pixel_port_pkg::MODE_SLAVE);
      p1       = (cfg.hblk > `FRAME_END_BLANK)
                 ? cfg.hblk - `FRAME_END_BLANK : 16'h0001;
      rowlen   = cfg.hact + cfg.hblk;
      row_go   = fifo_valid && (!slave || row_pend);  // see RQ6
      next_st  = st;
      next_cnt = cnt;
      next_row = row;
      next_vid = vid;
      next_strobe = STROBE_LIGHT_OUT;
      next_row_o  = ROW_START_SYNC_OUT;
      next_img_o  = IMAGE_START_SYNC_OUT;
      clr_expo = 1'b0;
      clr_row  = 1'b0;
      pop      = 1'b0;
      next_underrun = underrun & ~status_clr;
      if (pix_tick) begin
         next_cnt   = cnt + 16'h0001;
         next_row_o = 1'b0;
         next_img_o = 1'b0;
         unique case (st)
            pixel_port_pkg::S_IDLE: begin
               next_cnt = 16'h0000;
               if (cfg.run && (cfg.mode == pixel_port_pkg::MODE_MASTER
                               || cfg.mode == pixel_port_pkg::MODE_RSVD)) begin
                  next_st    = pixel_port_pkg::S_FSTART;
                  next_img_o = 1'b1;  // see RQ7
               end else if (cfg.run && expo_pend) begin
                  next_st  = pixel_port_pkg::S_EXPOSE;  // see RQ2
                  clr_expo = 1'b1;
               end
            end
            pixel_port_pkg::S_EXPOSE: begin
               if (at_end(cnt, cfg.expo)) begin
                  next_st    = pixel_port_pkg::S_FSTART;
                  next_cnt   = 16'h0000;
                  next_img_o = !slave;  // see RQ7
               end
            end
            pixel_port_pkg::S_FSTART, pixel_port_pkg::S_HBLANK: begin
               if (at_end(cnt, (st == pixel_port_pkg::S_FSTART) ? p1
                                                        : cfg.hblk)) begin
                  next_cnt = cnt;
                  if (row_go) begin
                     next_st    = pixel_port_pkg::S_ACTIVE;
                     next_cnt   = 16'h0000;
                     next_row_o = !slave;  // see RQ6
                     clr_row    = 1'b1;
                  end
               end
            end
            pixel_port_pkg::S_ACTIVE: begin
               if (at_end(cnt, cfg.hact)) begin
                  next_cnt = 16'h0000;
                  next_row = row + 16'h0001;
                  next_st  = at_end(row, cfg.nrows) ? pixel_port_pkg::S_FEND
                                                    : pixel_port_pkg::S_HBLANK;
               end
            end
            pixel_port_pkg::S_FEND: begin
               if (at_end(cnt, `FRAME_END_BLANK)) begin
                  next_st  = pixel_port_pkg::S_VBLANK;
                  next_cnt = 16'h0000;
                  next_row = 16'h0000;
               end
            end
            pixel_port_pkg::S_VBLANK: begin
               if (at_end(cnt, rowlen)) begin
                  next_cnt = 16'h0000;
                  next_row = row + 16'h0001;
                  if (at_end(row, cfg.vblk)) begin
                     next_st  = pixel_port_pkg::S_IDLE;
                     next_row = 16'h0000;
                  end
               end
            end
         endcase
         if (next_st == pixel_port_pkg::S_IDLE) begin
            next_row = 16'h0000;
         end
         // flags follow the state entered, one sample per period
         next_vid.frame = (next_st == pixel_port_pkg::S_FSTART)
                       || (next_st == pixel_port_pkg::S_ACTIVE)
                       || (next_st == pixel_port_pkg::S_HBLANK)
                       || (next_st == pixel_port_pkg::S_FEND);  // see RQ14
         next_vid.row  = (next_st == pixel_port_pkg::S_ACTIVE);  // see RQ5
         next_vid.data = 10'h000;
         if (next_st == pixel_port_pkg::S_ACTIVE) begin
            pop           = fifo_valid;  // see RQ11
            next_vid.data = fifo_valid ? fifo_data : 10'h000;
            next_underrun = next_underrun | ~fifo_valid;
         end
         next_strobe = (next_st == pixel_port_pkg::S_EXPOSE);
      end
      if (stby_s || !cfg.run) begin
         // see RQ9
         next_st     = pixel_port_pkg::S_IDLE;
         next_cnt    = 16'h0000;
         next_row    = 16'h0000;
         next_vid    = '0;
         next_strobe = 1'b0;
         pop         = 1'b0;
      end
      // a trigger edge in the clearing cycle stays pending
      next_expo_pend = (expo_pend & ~clr_expo) | (exp_rise & ~slave)
                     | (exp_rise & slave);
      next_row_pend  = (row_pend & ~clr_row) | (row_rise & slave);
   end
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         st                   <= pixel_port_pkg::S_IDLE;
         cnt                  <= 16'h0000;
         row                  <= 16'h0000;
         vid                  <= '0;
         expo_pend            <= 1'b0;
         row_pend             <= 1'b0;
         underrun             <= 1'b0;
         STROBE_LIGHT_OUT     <= 1'b0;
         ROW_START_SYNC_OUT   <= 1'b0;
         IMAGE_START_SYNC_OUT <= 1'b0;
      end else if (CE) begin
         st                   <= next_st;
         cnt                  <= next_cnt;
         row                  <= next_row;
         vid                  <= next_vid;
         expo_pend            <= next_expo_pend;
         row_pend             <= next_row_pend;
         underrun             <= next_underrun;
         STROBE_LIGHT_OUT     <= next_strobe;
         ROW_START_SYNC_OUT   <= next_row_o;
         IMAGE_START_SYNC_OUT <= next_img_o;
      end
   end
   assign DATA_OUT         = vid.data;
   assign ROW_ACTIVE_OUT   = vid.row;
   assign FRAME_ACTIVE_OUT = vid.frame;

   // ---- pin direction and address
   logic       next_sync_oe;
   logic [6:0] next_addr;
   always_comb begin
      next_sync_oe = (next_cfg.mode != pixel_port_pkg::MODE_SLAVE);
      next_addr    = {ADDR_BASE[6:2], s2[6], s2[5]};  // see RQ8
   end
   always_ff @(posedge CLOCK) begin
      if (!RST_N) begin
         VIDEO_OE            <= 1'b0;
         ROW_START_SYNC_OE   <= 1'b0;
         IMAGE_START_SYNC_OE <= 1'b0;
         SERIAL_ADDR         <= 7'h00;
      end else if (CE) begin
         VIDEO_OE            <= oe_s;  // see RQ1
         ROW_START_SYNC_OE   <= next_sync_oe;  // see RQ6
         IMAGE_START_SYNC_OE <= next_sync_oe;  // see RQ7
         SERIAL_ADDR         <= next_addr;
      end
   end

   // ---- assertions
   AST_OE_FLOATS: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (CE && !oe_s) |=> !VIDEO_OE) else $error("video pins driven"); // see RQ1
   AST_EXPO_TRIGGER: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (CE && st == pixel_port_pkg::S_IDLE && expo_pend && cfg.run && !stby_s
       && cfg.mode == pixel_port_pkg::MODE_SNAPSHOT)[*8]
      |-> st != pixel_port_pkg::S_IDLE)
      else $error("trigger did not start exposure"); // see RQ2
   AST_RESET_DEFAULTS: assert property (@(posedge CLOCK)
      !RST_N |=> (cfg.hact == `HACT_RST && !cfg.run && !cfg.inv
                  && st == pixel_port_pkg::S_IDLE))
      else $error("reset left a register off default"); // see RQ3
   AST_DATA_STEADY: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (CE && !pix_tick && !stby_s && cfg.run) |=> $stable(vid))
      else $error("pixel bus moved off the tick"); // see RQ4
   AST_ROW_IN_FRAME: assert property (@(posedge CLOCK) disable iff (!RST_N)
      ROW_ACTIVE_OUT |-> FRAME_ACTIVE_OUT && st == pixel_port_pkg::S_ACTIVE)
      else $error("row flag outside a frame row"); // see RQ14
   AST_SLAVE_ROW_IN: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (CE && cfg.mode == pixel_port_pkg::MODE_SLAVE && !apb_wr)
      |=> !ROW_START_SYNC_OE && !IMAGE_START_SYNC_OE)
      else $error("slave drives a sync pin"); // see RQ6
   AST_ADDR_PINS: assert property (@(posedge CLOCK) disable iff (!RST_N)
      CE |=> SERIAL_ADDR[1:0] == $past(s2[6:5]))
      else $error("address select not followed"); // see RQ8
   AST_STANDBY: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (CE && stby_s) |=> st == pixel_port_pkg::S_IDLE && !vid.frame)
      else $error("standby did not halt"); // see RQ9
   AST_CLOCK_RUNS: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (CE && RST_N && !apb_wr)[*4]
      |-> SAMPLE_CLOCK_OUT != $past(SAMPLE_CLOCK_OUT, 3))
      else $error("sample clock stopped"); // see RQ12
   AST_ONE_PIXEL: assert property (@(posedge CLOCK) disable iff (!RST_N)
      (CE && pix_tick && next_st == pixel_port_pkg::S_ACTIVE && fifo_valid
       && !stby_s && cfg.run)
      |=> ROW_ACTIVE_OUT && DATA_OUT == $past(fifo_data))
      else $error("row period without a sample"); // see RQ11
endmodule

// file: bench/pixel_capture_model.sv
// capture receiver model on the far side of the parallel pixel port
`timescale 1ns/1ns
module pixel_capture_model (
   input  wire logic       clk,       // core clock
   input  wire logic       oe,        // video pins driven
   input  wire logic       sclk,      // forwarded sample clock
   input  wire logic       row,       // row-active flag
   input  wire logic       frame,     // frame-active flag
   input  wire logic [9:0] data,      // pixel bus
   output int              total = 0, // pixels taken
   output int              last = 0,  // pixels in last frame
   output int              bad = 0,   // wrong order or outside frame
   output int              ticks = 0  // sample clock rises
);
   logic prev = 1'b0;
   logic fprev = 1'b0;
   int   cur = 0;
   // sample clock is found by edge detection in the core clock
   always @(posedge clk) begin
      prev <= sclk;
      fprev <= frame;
      if (fprev && !frame) begin
         last <= cur;
         cur <= 0;
      end
      if (sclk && !prev) begin
         ticks <= ticks + 1;
         if (oe && row) begin
            if (data !== total[9:0] || !frame) bad <= bad + 1;
            total <= total + 1;
            cur <= cur + 1;
         end
      end
   end
endmodule

// file: bench/tb.sv
// self-checking bench for the parallel pixel output port
`timescale 1ns/1ns
`include "pixel_port_consts.svh"
module tb;
   logic        CLOCK, RST_N, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, q;
   logic        PIX_VALID, PIX_READY, OUTPUT_ENABLE_IN, STANDBY_IN, e;
   logic        EXPOSURE_IN, ROW_START_SYNC_IN, IMAGE_START_SYNC_IN;
   logic        CTRL_ADDR_SELECT_LO, CTRL_ADDR_SELECT_HI, VIDEO_OE;
   logic [9:0]  PIX_DATA, DATA_OUT;
   logic        ROW_ACTIVE_OUT, FRAME_ACTIVE_OUT, SAMPLE_CLOCK_OUT;
   logic        ROW_START_SYNC_OUT, ROW_START_SYNC_OE, IMAGE_START_SYNC_OUT;
   logic        IMAGE_START_SYNC_OE, STROBE_LIGHT_OUT;
   logic [6:0]  SERIAL_ADDR;
   int          total, last, bad, ticks, t0, fail_count, check_count;
   int          row_syncs = 0;
   int          img_syncs = 0;
   logic [11:0] ra [5] = '{`ADDR_HACT, `ADDR_HBLK, `ADDR_NROWS,
                           `ADDR_VBLK, `ADDR_EXPO};
   logic [15:0] rv [5] = '{`HACT_RST, `HBLK_RST, `NROWS_RST,
                           `VBLK_RST, `EXPO_RST};
   pixel_port pixel_port_inst (.*);
   pixel_capture_model pixel_capture_model_inst (.clk(CLOCK),
      .oe(VIDEO_OE), .sclk(SAMPLE_CLOCK_OUT), .row(ROW_ACTIVE_OUT),
      .frame(FRAME_ACTIVE_OUT), .data(DATA_OUT), .total(total),
      .last(last), .bad(bad), .ticks(ticks));
   always #4 CLOCK = ~CLOCK;
   // pixel source counts up so the receiver can check order
   always @(posedge CLOCK) begin
      if (RST_N && PIX_VALID && PIX_READY) PIX_DATA <= PIX_DATA + 10'h001;
   end
   // cycles that the sync pins are driven high
   always @(posedge CLOCK) begin
      if (ROW_START_SYNC_OUT) row_syncs <= row_syncs + 1;
      if (IMAGE_START_SYNC_OUT) img_syncs <= img_syncs + 1;
   end
   task chk(input logic [31:0] s, input logic [31:0] x);
      check_count++;
      if (s !== x) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      PSEL <= 1'b1;
      PENABLE <= 1'b0;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLOCK);
      PENABLE <= 1'b1;
      do @(posedge CLOCK); while (PREADY !== 1'b1);
      q = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      @(posedge CLOCK);
   endtask
   task close_out;
      if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      {CLOCK, RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
      {STANDBY_IN, EXPOSURE_IN, ROW_START_SYNC_IN} = '0;
      {IMAGE_START_SYNC_IN, CTRL_ADDR_SELECT_HI, PIX_DATA} = '0;
      {CE, PIX_VALID, OUTPUT_ENABLE_IN, CTRL_ADDR_SELECT_LO} = 4'hF;
      fail_count = 0;
      check_count = 0;
      repeat (2) @(posedge CLOCK);
      RST_N <= 1'b1;
      repeat (40) @(posedge CLOCK);
      chk(PIX_READY, 32'h0);
      chk(SERIAL_ADDR, 32'h51);
      for (int i = 0; i < 5; i++) begin
         apb(1'b0, ra[i], 32'h0);
         chk(q, rv[i]);
      end
      apb(1'b0, 12'h020, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(q, 32'h0);
      apb(1'b1, `ADDR_HACT, 32'h4);
      apb(1'b1, `ADDR_HBLK, 32'h18);
      apb(1'b1, `ADDR_NROWS, 32'h2);
      apb(1'b1, `ADDR_VBLK, 32'h1);
      apb(1'b1, `ADDR_CTRL, 32'h1);
      repeat (1000) @(posedge CLOCK);
      chk(last, 32'h8);
      chk(bad, 32'h0);
      chk({ROW_START_SYNC_OE, IMAGE_START_SYNC_OE}, 32'h3);
      chk(row_syncs > 0 && img_syncs > 0, 32'h1);
      apb(1'b1, `ADDR_CTRL, 32'h0);
      t0 = ticks;
      repeat (60) @(posedge CLOCK);
      chk(ticks - t0 >= 9, 32'h1);
      chk(ticks - t0 <= 12, 32'h1);
      apb(1'b1, `ADDR_CTRL, 32'h3);
      EXPOSURE_IN <= 1'b1;
      repeat (20) @(posedge CLOCK);
      chk(STROBE_LIGHT_OUT, 32'h1);
      STANDBY_IN <= 1'b1;
      repeat (10) @(posedge CLOCK);
      chk({ROW_ACTIVE_OUT, FRAME_ACTIVE_OUT, STROBE_LIGHT_OUT}, 32'h0);
      apb(1'b0, `ADDR_STATUS, 32'h0);
      chk(q[11], 32'h1);
      STANDBY_IN <= 1'b0;
      apb(1'b1, `ADDR_CTRL, 32'h5);
      repeat (5) @(posedge CLOCK);
      chk({ROW_START_SYNC_OE, IMAGE_START_SYNC_OE}, 32'h0);
      OUTPUT_ENABLE_IN <= 1'b0;
      repeat (5) @(posedge CLOCK);
      chk(VIDEO_OE, 32'h0);
      apb(1'b1, `ADDR_PCLK_CTL, 32'h10);
      apb(1'b0, `ADDR_PCLK_CTL, 32'h0);
      chk(q, 32'h10);
      close_out;
   end
   initial begin
      #100000;
      fail_count++;
      close_out;
   end
endmodule
